// ==== inc/asdtc_pkg.sv ====
package asdtc_pkg;

    // register map, byte offsets on the serial register port
    localparam logic [7:0]  THRESH_OFFSET   = 8'h22;
    localparam logic [7:0]  CTRL_OFFSET     = 8'h23;
    localparam logic [15:0] THRESH_RESET    = 16'h0000;
    localparam logic [15:0] CTRL_RESET      = 16'h0000;

    // threshold register fields
    localparam int LEVEL_MSB   = 5;
    localparam int LEVEL_LSB   = 1;
    localparam int REF_SEL_BIT = 0;

    // conversion control register fields
    localparam int MAINS_BIT   = 10;
    localparam int SEQ_MSB     = 9;
    localparam int SEQ_LSB     = 8;
    localparam int DIAG_MSB    = 7;
    localparam int DIAG_LSB    = 4;
    localparam int CHAN_MSB    = 3;
    localparam int CHAN_LSB    = 0;

    // converter wake-up time, least time so round up
    localparam int CLK_PERIOD_PS = 25_000;
    localparam int WAKE_TIME_US  = 100;
    localparam int WAKE_CYCLES   =
        (WAKE_TIME_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        SEQ_IDLE       = 2'h0,
        SEQ_SINGLE     = 2'h1,
        SEQ_CONTINUOUS = 2'h2,
        SEQ_POWER_DOWN = 2'h3
    } asdtc_seq_type;

    typedef struct packed {
        logic [4:0] comparator_level;
        logic       threshold_reference_select;
    } asdtc_thresh_type;

    typedef struct packed {
        logic          diag_mains_rejection_on;
        asdtc_seq_type sequence_command;
        logic [3:0]    diag_convert_on;
        logic [3:0]    chan_convert_on;
    } asdtc_ctrl_type;

endpackage

// ==== rtl/asdtc_wake_timer.sv ====
`timescale 1ns/10ps
`default_nettype none

// counts out the converter wake-up; a new start restarts the count
module asdtc_wake_timer #(
    parameter int CYCLES = asdtc_pkg::WAKE_CYCLES
) (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic start_i,
    output logic      done_o
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          run_q;
    logic          run_d;
    logic          done_d;

    ////////////////////////////////////////////////////////////////////
    // next count
    always_comb begin
        cnt_d  = cnt_q;
        run_d  = run_q;
        done_d = 1'b0;
        if (start_i) begin
            cnt_d = '0;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q == LAST) begin
                run_d  = 1'b0;
                done_d = 1'b1;   // one pulse, CYCLES after start
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end
    end

    // registers only
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            run_q  <= run_d;
            done_o <= done_d;
        end
    end

endmodule

`default_nettype wire

// ==== rtl/asdtc_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE_01: 5-bit comparator level, threshold bits 5:1, reset zero, all inputs.
// RULE_02: threshold bit 0 picks supply-tracking or fixed 16 V reference.
// RULE_03: bit 10 sets diagnostic rate: 4.8 kSPS, or 20 SPS mains-rejecting.
// RULE_04: code 00 stops continuous runs, powers converter up if off.
// RULE_05: busy flag stays high while converter powers up, drops when ready.
// RULE_06: host waits out power-up before starting a single or continuous run.
// RULE_07: code 01 converts every enabled channel and diagnostic exactly once.
// RULE_08: pass leaves sequence field set; host rewrites 01 for another pass.
// RULE_09: code 01 from power-down powers up first; host allows 100 us.
// RULE_10: code 10 cycles through all enabled slots repeatedly until stopped.
// RULE_11: enabled set stays frozen in a run, whatever the enable bits say.
// RULE_12: to change the set, host stops, rewrites enables, then restarts.
// RULE_13: host writes idle code before going from continuous to single pass.
// RULE_14: code 11 halts continuous conversion and powers converter down.
// RULE_15: host polls busy flag low before enabling another sequence.
// RULE_16: control bits 7:4 enable diagnostics 3..0, bits 3:0 channels D..A.
// RULE_17: reserved bits read zero and ignore writes.
module asdtc_ctrl #(
    parameter int WAKE_CYCLES = asdtc_pkg::WAKE_CYCLES
) (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic [15:0]      reg_rdata_o,
    output logic             reg_rvalid_o,
    input  wire logic        conv_done_i,
    output logic             conv_start_o,
    output logic [2:0]       conv_slot_o,
    output logic             adc_power_on_o,
    output logic             diag_mains_rejection_on_o,
    output logic             conversion_busy_o,
    output logic [4:0]       comparator_level_o,
    output logic             threshold_reference_select_o
);

    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_WAKE  = 3'h1,
        ST_IDLE  = 3'h3,
        ST_CONV  = 3'h2,
        ST_WAIT  = 3'h6
    } asdtc_state_type;

    // lowest enabled slot at or above from; msb flags a hit
    function automatic logic [3:0] next_slot(input logic [7:0] set,
                                             input logic [3:0] from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (set[i] && (4'(i) >= from)) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    asdtc_pkg::asdtc_thresh_type th_q, th_d;
    asdtc_pkg::asdtc_ctrl_type   ctl_q, ctl_d;
    asdtc_state_type             state_q, state_d;
    logic [7:0]  set_q, set_d;
    logic [2:0]  slot_q, slot_d;
    logic        cont_q, cont_d;
    logic        pend_q, pend_d;
    logic        pcont_q, pcont_d;
    logic        start_d;
    logic        busy_d;
    logic        wake_start;
    logic        wake_done;
    logic        th_wr;
    logic        ctl_wr;
    logic [3:0]  hit;
    logic [3:0]  first;
    logic [15:0] rdata_d;
    asdtc_pkg::asdtc_seq_type cmd;

    assign th_wr  = reg_wr_i && (reg_addr_i == asdtc_pkg::THRESH_OFFSET);
    assign ctl_wr = reg_wr_i && (reg_addr_i == asdtc_pkg::CTRL_OFFSET);
    assign cmd    = asdtc_pkg::asdtc_seq_type'(
                    reg_wdata_i[asdtc_pkg::SEQ_MSB:asdtc_pkg::SEQ_LSB]);
    assign hit    = next_slot(set_q, {1'b0, slot_q} + 4'h1);
    assign first  = next_slot(set_q, 4'h0);

    asdtc_wake_timer #(
        .CYCLES (WAKE_CYCLES)
    ) u_wake (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (wake_start),
        .done_o    (wake_done)
    );

    ////////////////////////////////////////////////////////////////////
    // register file; only defined fields stored, reserved bits dropped
    always_comb begin
        th_d  = th_q;
        ctl_d = ctl_q;
        if (th_wr) begin
            th_d.comparator_level = reg_wdata_i[asdtc_pkg::LEVEL_MSB:
                                    asdtc_pkg::LEVEL_LSB];   // RULE_01
            th_d.threshold_reference_select =
                reg_wdata_i[asdtc_pkg::REF_SEL_BIT];          // RULE_02
        end
        if (ctl_wr) begin
            ctl_d.diag_mains_rejection_on =
                reg_wdata_i[asdtc_pkg::MAINS_BIT];            // RULE_03
            ctl_d.sequence_command = cmd;                     // RULE_08
            ctl_d.diag_convert_on  = reg_wdata_i[asdtc_pkg::DIAG_MSB:
                                     asdtc_pkg::DIAG_LSB];    // RULE_16
            ctl_d.chan_convert_on  = reg_wdata_i[asdtc_pkg::CHAN_MSB:
                                     asdtc_pkg::CHAN_LSB];    // RULE_16
        end
        // unmapped offsets answer zero, reserved bits read zero
        rdata_d = 16'h0000;
        if (reg_addr_i == asdtc_pkg::THRESH_OFFSET) begin
            rdata_d = {10'h000, th_q};                        // RULE_17
        end else if (reg_addr_i == asdtc_pkg::CTRL_OFFSET) begin
            rdata_d = {5'h00, ctl_q};                         // RULE_17
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer; commands written this cycle override the walk
    always_comb begin
        state_d    = state_q;
        set_d      = set_q;
        slot_d     = slot_q;
        cont_d     = cont_q;
        pend_d     = pend_q;
        pcont_d    = pcont_q;
        start_d    = 1'b0;
        wake_start = 1'b0;
        unique case (state_q)
            ST_OFF: begin
            end
            ST_WAKE: begin
                if (wake_done) begin
                    state_d = ST_IDLE;                        // RULE_05
                end
            end
            ST_IDLE: begin
                if (pend_q) begin
                    // enable set frozen here for the whole run
                    set_d  = {ctl_q.diag_convert_on,
                              ctl_q.chan_convert_on};         // RULE_11
                    pend_d = 1'b0;
                    if (|set_d) begin
                        slot_d  = 3'(next_slot(set_d, 4'h0)); // RULE_07
                        cont_d  = pcont_q;
                        state_d = ST_CONV;
                    end
                end
            end
            ST_CONV: begin
                start_d = 1'b1;
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done_i) begin
                    if (hit[3]) begin
                        slot_d  = hit[2:0];                   // RULE_07
                        state_d = ST_CONV;
                    end else if (cont_q) begin
                        slot_d  = first[2:0];                 // RULE_10
                        state_d = ST_CONV;
                    end else begin
                        state_d = ST_IDLE;                    // RULE_08
                    end
                end
            end
            default: state_d = ST_OFF;
        endcase
        if (ctl_wr) begin
            unique case (cmd)
                asdtc_pkg::SEQ_IDLE: begin
                    cont_d = 1'b0;                            // RULE_04
                    pend_d = 1'b0;
                end
                asdtc_pkg::SEQ_SINGLE: begin
                    pend_d  = 1'b1;                           // RULE_07
                    pcont_d = 1'b0;
                end
                asdtc_pkg::SEQ_CONTINUOUS: begin
                    pend_d  = 1'b1;                           // RULE_10
                    pcont_d = 1'b1;
                end
                asdtc_pkg::SEQ_POWER_DOWN: begin
                    cont_d  = 1'b0;                           // RULE_14
                    pend_d  = 1'b0;
                    state_d = ST_OFF;
                end
            endcase
            // leaving power-down by any non-off code wakes the converter
            if (state_q == ST_OFF && cmd != asdtc_pkg::SEQ_POWER_DOWN) begin
                state_d    = ST_WAKE;                         // RULE_09
                wake_start = 1'b1;                            // RULE_04
            end
        end
        busy_d = pend_d || (state_d != ST_IDLE && state_d != ST_OFF);
    end

    // registers only
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            th_q              <= asdtc_pkg::asdtc_thresh_type'(
                                 asdtc_pkg::THRESH_RESET[5:0]);
            ctl_q             <= asdtc_pkg::asdtc_ctrl_type'(
                                 asdtc_pkg::CTRL_RESET[10:0]);
            state_q           <= ST_IDLE;
            set_q             <= 8'h00;
            slot_q            <= 3'h0;
            cont_q            <= 1'b0;
            pend_q            <= 1'b0;
            pcont_q           <= 1'b0;
            conv_start_o      <= 1'b0;
            conv_slot_o       <= 3'h0;
            adc_power_on_o    <= 1'b1;
            conversion_busy_o <= 1'b0;
            reg_rdata_o       <= 16'h0000;
            reg_rvalid_o      <= 1'b0;
            diag_mains_rejection_on_o    <= 1'b0;
            comparator_level_o           <= 5'h00;
            threshold_reference_select_o <= 1'b0;
        end else begin
            th_q              <= th_d;
            ctl_q             <= ctl_d;
            state_q           <= state_d;
            set_q             <= set_d;
            slot_q            <= slot_d;
            cont_q            <= cont_d;
            pend_q            <= pend_d;
            pcont_q           <= pcont_d;
            conv_start_o      <= start_d;
            conv_slot_o       <= slot_q;
            adc_power_on_o    <= (state_d != ST_OFF);          // RULE_14
            conversion_busy_o <= busy_d;                       // RULE_05
            reg_rdata_o       <= reg_rd_i ? rdata_d : 16'h0000;
            reg_rvalid_o      <= reg_rd_i;
            diag_mains_rejection_on_o    <= ctl_d.diag_mains_rejection_on;
            comparator_level_o           <= th_d.comparator_level;
            threshold_reference_select_o <= th_d.threshold_reference_select;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    level_write_a: assert property (th_wr |=> comparator_level_o ==  // RULE_01
        $past(reg_wdata_i[5:1])) else $error("comparator level not taken");
    ref_write_a: assert property (th_wr |=>                           // RULE_02
        threshold_reference_select_o == $past(reg_wdata_i[0]))
        else $error("reference select not taken");
    mains_write_a: assert property (ctl_wr |=>                        // RULE_03
        diag_mains_rejection_on_o == $past(reg_wdata_i[10]))
        else $error("mains rejection bit not taken");
    idle_stop_a: assert property (ctl_wr &&                           // RULE_04
        cmd == asdtc_pkg::SEQ_IDLE |=> !cont_q && !pend_q)
        else $error("idle code did not stop");
    wake_busy_a: assert property (state_q == ST_WAKE |->              // RULE_05
        conversion_busy_o && adc_power_on_o)
        else $error("busy low during wake-up");
    single_start_a: assert property (state_q == ST_IDLE && pend_q &&  // RULE_07
        !ctl_wr && |{ctl_q.diag_convert_on, ctl_q.chan_convert_on}
        |=> state_q == ST_CONV ##1 conv_start_o)
        else $error("single pass did not start");
    seq_kept_a: assert property (!ctl_wr |=>                          // RULE_08
        $stable(ctl_q.sequence_command))
        else $error("sequence field changed without write");
    cont_wrap_a: assert property (state_q == ST_WAIT && conv_done_i   // RULE_10
        && cont_q && !ctl_wr |=> state_q == ST_CONV)
        else $error("continuous run stopped");
    set_frozen_a: assert property (state_q != ST_IDLE |=>             // RULE_11
        $stable(set_q)) else $error("enabled set changed in run");
    power_down_a: assert property (ctl_wr &&                          // RULE_14
        cmd == asdtc_pkg::SEQ_POWER_DOWN |=> state_q == ST_OFF &&
        !adc_power_on_o ##1 !conv_start_o)
        else $error("power-down code ignored");
    reserved_zero_a: assert property (reg_rvalid_o |->                // RULE_17
        reg_rdata_o[15:11] == 5'h00) else $error("reserved bits set");

endmodule

`default_nettype wire

// ==== bench/asdtc_conv_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// converter stand-in: answers each start with one done pulse
// after delay_i idle cycles, so prompt and slow replies can be mixed
module asdtc_conv_model (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       conv_start_i,
    input  wire logic [3:0] delay_i,
    output logic            conv_done_o
);
    logic [3:0] cnt_q;
    logic       busy_q;

    ////////////////////////////////////////////////////////////////////
    // one conversion in flight at a time, a new start restarts it
    always_ff @(posedge mclk_i) begin
        conv_done_o <= 1'b0;
        if (sys_rst_i) begin
            busy_q <= 1'b0;
            cnt_q  <= 4'h0;
        end else if (conv_start_i) begin
            busy_q <= 1'b1;
            cnt_q  <= delay_i;
        end else if (busy_q) begin
            if (cnt_q == 4'h0) begin
                busy_q      <= 1'b0;
                conv_done_o <= 1'b1;
            end else begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

`default_nettype wire

// ==== bench/tb_asdtc_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp, msg) begin comparisons++; \
    if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %0t %s", $time, msg); end end

module tb_asdtc_ctrl;
    // short wake count keeps the run brief
    localparam int WAKE = 8;

    logic        mclk      = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic        reg_wr    = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_rd    = 1'b0;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic        conv_done;
    logic        conv_start;
    logic [2:0]  conv_slot;
    logic        adc_power_on;
    logic        mains_on;
    logic        conv_busy;
    logic [4:0]  comp_level;
    logic        thr_ref;
    logic [3:0]  dly       = 4'h0;
    int          err_total   = 0;
    int          comparisons = 0;
    logic [2:0]  slots[$];

    asdtc_ctrl #(.WAKE_CYCLES(WAKE)) u_asdtc_ctrl (
        .mclk_i                       (mclk),
        .sys_rst_i                    (sys_rst),
        .reg_addr_i                   (reg_addr),
        .reg_wr_i                     (reg_wr),
        .reg_wdata_i                  (reg_wdata),
        .reg_rd_i                     (reg_rd),
        .reg_rdata_o                  (reg_rdata),
        .reg_rvalid_o                 (reg_rvalid),
        .conv_done_i                  (conv_done),
        .conv_start_o                 (conv_start),
        .conv_slot_o                  (conv_slot),
        .adc_power_on_o               (adc_power_on),
        .diag_mains_rejection_on_o    (mains_on),
        .conversion_busy_o            (conv_busy),
        .comparator_level_o           (comp_level),
        .threshold_reference_select_o (thr_ref)
    );

    asdtc_conv_model u_asdtc_conv_model (
        .mclk_i       (mclk),
        .sys_rst_i    (sys_rst),
        .conv_start_i (conv_start),
        .delay_i      (dly),
        .conv_done_o  (conv_done)
    );

    always #12.5 mclk = ~mclk;

    // log every slot the block launches, in order
    always @(posedge mclk) begin
        if (conv_start === 1'b1) slots.push_back(conv_slot);
    end

    ////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // answer lands on the same edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rvalid, 1'b1, "no read answer")
        `CHK(reg_rdata, e, "read data")
    endtask

    task automatic idle(input int lim);
        int n = 0;
        // look just after each edge so the flag has settled
        while (conv_busy !== 1'b0 && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (conv_busy !== 1'b0) begin
            err_total++;
            $display("MISMATCH %0t busy stuck high", $time);
            summarize();
        end
    endtask

    task automatic need(input int cnt, input int lim);
        int n = 0;
        while (slots.size() < cnt && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (slots.size() < cnt) begin
            err_total++;
            $display("MISMATCH %0t too few conversions", $time);
            summarize();
        end
    endtask

    task automatic expect_slots(input logic [2:0] e[$]);
        `CHK(slots.size(), e.size(), "slot count")
        foreach (e[i]) begin
            if (i < slots.size()) begin
                `CHK(slots[i], e[i], "slot order")
            end
        end
        slots.delete();
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK(adc_power_on, 1'b1, "power after reset")
        `CHK(conv_busy, 1'b0, "busy after reset")
        rd(8'h22, 16'h0000);
        rd(8'h23, 16'h0000);
        rd(8'h24, 16'h0000);
    endtask

    // reserved bits written high must not stick
    task automatic t_thresh();
        wr(8'h22, 16'hFFFF);
        `CHK(comp_level, 5'h1F, "level")
        `CHK(thr_ref, 1'b1, "ref select")
        rd(8'h22, 16'h003F);
        wr(8'h22, 16'h0014);
        `CHK(comp_level, 5'h0A, "level")
        `CHK(thr_ref, 1'b0, "ref select")
        rd(8'h22, 16'h0014);
    endtask

    task automatic t_mains();
        wr(8'h23, 16'hFC00);
        `CHK(mains_on, 1'b1, "mains on")
        rd(8'h23, 16'h0400);
        wr(8'h23, 16'h0000);
        `CHK(mains_on, 1'b0, "mains off")
    endtask

    // slow converter; field keeps 01 after the pass
    task automatic t_single();
        dly = 4'h3;
        wr(8'h23, 16'h0191);
        `CHK(conv_busy, 1'b1, "busy in pass")
        idle(300);
        expect_slots('{3'h0, 3'h4, 3'h7});
        rd(8'h23, 16'h0191);
        wr(8'h23, 16'h0191);
        idle(300);
        expect_slots('{3'h0, 3'h4, 3'h7});
    endtask

    // enable writes mid-run must not widen the frozen set
    task automatic t_cont();
        dly = 4'h0;
        wr(8'h23, 16'h0203);
        need(6, 200);
        wr(8'h23, 16'h020F);
        need(12, 200);
        wr(8'h23, 16'h000F);
        idle(100);
        foreach (slots[i]) begin
            `CHK(slots[i], 3'(i % 2), "loop slot")
        end
        slots.delete();
        wr(8'h23, 16'h0108);
        idle(100);
        expect_slots('{3'h3});
    endtask

    task automatic t_power();
        wr(8'h23, 16'h0300);
        `CHK(adc_power_on, 1'b0, "power down")
        wr(8'h23, 16'h0101);
        `CHK(adc_power_on, 1'b1, "auto wake")
        `CHK(conv_busy, 1'b1, "busy in wake")
        // last edge of the wake count: still busy, nothing launched
        repeat (WAKE) @(posedge mclk);
        #1;
        `CHK(slots.size(), 0, "early conversion")
        `CHK(conv_busy, 1'b1, "busy left wake early")
        need(1, 40);
        idle(100);
        expect_slots('{3'h0});
        wr(8'h23, 16'h0201);
        need(1, 40);
        wr(8'h23, 16'h0301);
        repeat (2) @(posedge mclk);
        `CHK(conv_busy, 1'b0, "abort busy")
        `CHK(adc_power_on, 1'b0, "abort power")
        slots.delete();
        wr(8'h23, 16'h0000);
        `CHK(adc_power_on, 1'b1, "idle wake")
        `CHK(conv_busy, 1'b1, "busy in wake")
        idle(WAKE + 4);
        `CHK(slots.size(), 0, "idle converted")
    endtask

    ////////////////////////////////////////////////////////////////////
    // reset for 20 cycles, then every scenario in turn
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_thresh();
        t_mains();
        t_single();
        t_cont();
        t_power();
        summarize();
    end
endmodule

`default_nettype wire
